// file: verilog/t16cp_pkg.sv
// register map, field positions and reset values for the timer16 compare/prescaler block
package t16cp_pkg;
	localparam logic [7:0] ADDR_FLAGS_DATA = 8'h36;
	localparam logic [7:0] IO_OFFSET       = 8'h20;
	localparam logic [7:0] ADDR_FLAGS_IO   = 8'h16;
	localparam logic [7:0] ADDR_MASK       = 8'h6f;
	localparam logic [7:0] ADDR_CMP_A      = 8'h88;
	localparam logic [7:0] ADDR_CMP_B      = 8'h8a;
	localparam logic [7:0] ADDR_HIGH_STEP  = 8'h01;
	localparam logic [7:0] ADDR_FORCE      = 8'h82;
	localparam logic [7:0] ADDR_SYNC       = 8'h43;
	localparam logic [7:0] ADDR_CLKSEL     = 8'h81;
	localparam int BIT_CAPTURE  = 5;
	localparam int BIT_MATCH_B  = 2;
	localparam int BIT_MATCH_A  = 1;
	localparam int BIT_OVERFLOW = 0;
	localparam int BIT_FORCE_A  = 7;
	localparam int BIT_FORCE_B  = 6;
	localparam int BIT_SYNC_HOLD = 7;
	localparam int BIT_PSC_RESET = 0;
	localparam logic [7:0] IRQ_BITS_MASK = 8'h27;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	localparam logic [15:0] RESET_CMP    = 16'h0000;
	localparam logic [2:0] CS_STOP   = 3'h0;
	localparam logic [2:0] CS_DIRECT = 3'h1;
	localparam logic [2:0] CS_DIV8   = 3'h2;
	localparam logic [2:0] CS_DIV64  = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1K  = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PSC_WIDTH = 10;
	localparam logic [9:0] TAP_8    = 10'h007;
	localparam logic [9:0] TAP_64   = 10'h03f;
	localparam logic [9:0] TAP_256  = 10'h0ff;
	localparam logic [9:0] TAP_1024 = 10'h3ff;
endpackage

// file: verilog/t16cp_core.sv
// timer16 compare channels, interrupt mask/flags and shared prescaler
//Contract
// - channel A 16-bit value compared against counter continuously; match drives irq or pin.
// - channel B 16-bit value compared against counter continuously; match drives irq or pin.
// - 16-bit compare writes land both bytes at once via shared high-byte temp.
// - low byte decodes at base offset, high byte at base plus one.
// - capture irq requested only when mask bit 5, global enable and flag set.
// - compare-B irq only when mask bit 2, global enable and flag set.
// - compare-A irq only when mask bit 1, global enable and flag set.
// - overflow irq only when mask bit 0, global enable and flag set.
// - capture flag set by capture event, or by reaching TOP when capture is TOP.
// - flags clear on vector execution or writing one to the bit.
// - match flags set in timer tick following counter equal to compare value.
// - forced-compare strobes never set match flags.
// - overflow flag set on overflow in normal and clear-on-match modes; else mode-dependent.
// - flag register at data offset 0x36, and 0x16 for short io accesses.
// - one prescaler shared by both timers, each picks its own tap.
// - clock select 0x01 ticks timer every system clock.
// - prescaler taps divide by 8, 64, 256 and 1024.
// - prescaler free-runs regardless of clock select settings.
// - prescaler reset restarts period for every attached timer.
// - prescaler held reset while reset bit one; auto-clears unless sync hold set.
// - writing sync hold to zero clears the prescaler reset bit.
// - select 000 stops timer; 110/111 use external falling/rising edge ticks.
`timescale 1ns/1ps
module t16cp_core #(
	parameter int CNT_WIDTH = 16
) (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic        io_space_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic        global_irq_en_i,
	input  wire logic [15:0] timer16_count_i,
	input  wire logic        count_tick_i,
	input  wire logic        overflow_evt_i,
	input  wire logic        capture_evt_i,
	input  wire logic        capture_is_top_i,
	input  wire logic        top_reached_i,
	input  wire logic        wave_mode_ovf_i,
	input  wire logic        ext_rise_i,
	input  wire logic        ext_fall_i,
	input  wire logic [2:0]  other_clock_source_sel_i,
	input  wire logic [3:0]  vector_ack_i,
	output logic [7:0]       rdata_o,
	output logic [3:0]       irq_req_o,
	output logic             match_a_o,
	output logic             match_b_o,
	output logic             force_match_a_o,
	output logic             force_match_b_o,
	output logic             timer16_tick_o,
	output logic             other_tick_o,
	output logic [7:0]       timer16_irq_flags_o
);
	// elaboration guard: ports and compares are fixed at 16 bits
	if (CNT_WIDTH != 16) begin
		$error("t16cp_core serves only a 16-bit counter");
	end

	logic [7:0]  temp_high_q;
	logic [15:0] compare_a_value_q;
	logic [15:0] compare_b_value_q;
	logic [7:0]  timer16_irq_mask_q;
	logic [7:0]  timer16_irq_flags_q;
	logic [2:0]  clock_source_sel_q;
	logic        timer_sync_hold_q;
	logic        shared_prescaler_reset_q;
	logic [9:0]  psc_q;
	logic        eq_a_q;
	logic        eq_b_q;

	// io addresses sit 0x20 below the data-space ones
	function automatic logic hit(input logic [7:0] a, input logic io, input logic [7:0] base);
		hit = io ? (a == base - t16cp_pkg::IO_OFFSET) : (a == base);
	endfunction

	function automatic logic tap_tick(input logic [2:0] sel, input logic [9:0] psc,
		input logic rise, input logic fall);
		unique case (sel)
			t16cp_pkg::CS_STOP:     tap_tick = 1'b0;
			t16cp_pkg::CS_DIRECT:   tap_tick = 1'b1;
			t16cp_pkg::CS_DIV8:     tap_tick = (psc[2:0] == t16cp_pkg::TAP_8[2:0]);
			t16cp_pkg::CS_DIV64:    tap_tick = (psc[5:0] == t16cp_pkg::TAP_64[5:0]);
			t16cp_pkg::CS_DIV256:   tap_tick = (psc[7:0] == t16cp_pkg::TAP_256[7:0]);
			t16cp_pkg::CS_DIV1K:    tap_tick = (psc == t16cp_pkg::TAP_1024);
			t16cp_pkg::CS_EXT_FALL: tap_tick = fall;
			t16cp_pkg::CS_EXT_RISE: tap_tick = rise;
		endcase
	endfunction

	logic wr_flags, wr_mask, wr_a_lo, wr_a_hi, wr_b_lo, wr_b_hi, wr_force, wr_sync, wr_cs;
	always_comb begin
		wr_flags = wr_i && (io_space_i ? addr_i == t16cp_pkg::ADDR_FLAGS_IO
			: addr_i == t16cp_pkg::ADDR_FLAGS_DATA);
		wr_mask  = wr_i && !io_space_i && addr_i == t16cp_pkg::ADDR_MASK;
		wr_a_lo  = wr_i && !io_space_i && addr_i == t16cp_pkg::ADDR_CMP_A;
		wr_a_hi  = wr_i && !io_space_i &&
			addr_i == t16cp_pkg::ADDR_CMP_A + t16cp_pkg::ADDR_HIGH_STEP;
		wr_b_lo  = wr_i && !io_space_i && addr_i == t16cp_pkg::ADDR_CMP_B;
		wr_b_hi  = wr_i && !io_space_i &&
			addr_i == t16cp_pkg::ADDR_CMP_B + t16cp_pkg::ADDR_HIGH_STEP;
		wr_force = wr_i && !io_space_i && addr_i == t16cp_pkg::ADDR_FORCE;
		wr_sync  = wr_i && hit(addr_i, io_space_i, t16cp_pkg::ADDR_SYNC);
		wr_cs    = wr_i && !io_space_i && addr_i == t16cp_pkg::ADDR_CLKSEL;
	end

	// high byte parks in temp; low-byte write commits both
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			temp_high_q       <= t16cp_pkg::RESET_BYTE;
			compare_a_value_q <= t16cp_pkg::RESET_CMP;
			compare_b_value_q <= t16cp_pkg::RESET_CMP;
		end else begin
			if (wr_a_hi || wr_b_hi) temp_high_q <= wdata_i;
			if (wr_a_lo) compare_a_value_q <= {temp_high_q, wdata_i};
			if (wr_b_lo) compare_b_value_q <= {temp_high_q, wdata_i};
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			timer16_irq_mask_q <= t16cp_pkg::RESET_BYTE;
			clock_source_sel_q <= t16cp_pkg::CS_STOP;
		end else begin
			if (wr_mask) timer16_irq_mask_q <= wdata_i & t16cp_pkg::IRQ_BITS_MASK;
			if (wr_cs) clock_source_sel_q <= wdata_i[2:0];
		end
	end

	// equality remembered so the flag lands on the next timer tick
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			eq_a_q <= 1'b0;
			eq_b_q <= 1'b0;
		end else if (timer16_tick_o) begin
			eq_a_q <= (timer16_count_i == compare_a_value_q);
			eq_b_q <= (timer16_count_i == compare_b_value_q);
		end
	end

	logic [7:0] hw_set;
	always_comb begin
		hw_set = t16cp_pkg::RESET_BYTE;
		hw_set[t16cp_pkg::BIT_MATCH_A] = eq_a_q && timer16_tick_o;
		hw_set[t16cp_pkg::BIT_MATCH_B] = eq_b_q && timer16_tick_o;
		hw_set[t16cp_pkg::BIT_OVERFLOW] = overflow_evt_i && wave_mode_ovf_i;
		hw_set[t16cp_pkg::BIT_CAPTURE] = capture_is_top_i ? top_reached_i
			: capture_evt_i;
	end

	logic [7:0] sw_clr;
	always_comb begin
		sw_clr = (wr_flags ? wdata_i : t16cp_pkg::RESET_BYTE) & t16cp_pkg::IRQ_BITS_MASK;
		sw_clr[t16cp_pkg::BIT_CAPTURE]  = sw_clr[t16cp_pkg::BIT_CAPTURE] | vector_ack_i[3];
		sw_clr[t16cp_pkg::BIT_MATCH_B]  = sw_clr[t16cp_pkg::BIT_MATCH_B] | vector_ack_i[2];
		sw_clr[t16cp_pkg::BIT_MATCH_A]  = sw_clr[t16cp_pkg::BIT_MATCH_A] | vector_ack_i[1];
		sw_clr[t16cp_pkg::BIT_OVERFLOW] = sw_clr[t16cp_pkg::BIT_OVERFLOW] | vector_ack_i[0];
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) timer16_irq_flags_q <= t16cp_pkg::RESET_BYTE;
		else timer16_irq_flags_q <= ((timer16_irq_flags_q & ~sw_clr) | hw_set)
			& t16cp_pkg::IRQ_BITS_MASK;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) timer16_irq_flags_o <= t16cp_pkg::RESET_BYTE;
		else timer16_irq_flags_o <= ((timer16_irq_flags_q & ~sw_clr) | hw_set)
			& t16cp_pkg::IRQ_BITS_MASK;
	end

	logic [7:0] req_next;
	always_comb begin
		req_next = ((timer16_irq_flags_q & ~sw_clr) | hw_set) & timer16_irq_mask_q
			& {8{global_irq_en_i}};
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) irq_req_o <= 4'h0;
		else irq_req_o <= {req_next[t16cp_pkg::BIT_CAPTURE],
			req_next[t16cp_pkg::BIT_MATCH_B],
			req_next[t16cp_pkg::BIT_MATCH_A],
			req_next[t16cp_pkg::BIT_OVERFLOW]};
	end

	// match pulses to the waveform unit; strobes travel apart, never into flags
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			match_a_o       <= 1'b0;
			match_b_o       <= 1'b0;
			force_match_a_o <= 1'b0;
			force_match_b_o <= 1'b0;
		end else begin
			match_a_o       <= eq_a_q && timer16_tick_o;
			match_b_o       <= eq_b_q && timer16_tick_o;
			force_match_a_o <= wr_force && wdata_i[t16cp_pkg::BIT_FORCE_A];
			force_match_b_o <= wr_force && wdata_i[t16cp_pkg::BIT_FORCE_B];
		end
	end

	logic psc_reset_next;
	always_comb begin
		psc_reset_next = shared_prescaler_reset_q && timer_sync_hold_q;
		if (wr_sync) psc_reset_next = wdata_i[t16cp_pkg::BIT_PSC_RESET]
			&& wdata_i[t16cp_pkg::BIT_SYNC_HOLD];
		if (wr_sync && wdata_i[t16cp_pkg::BIT_PSC_RESET] && !wdata_i[t16cp_pkg::BIT_SYNC_HOLD])
			psc_reset_next = 1'b1;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			timer_sync_hold_q        <= 1'b0;
			shared_prescaler_reset_q <= 1'b0;
		end else begin
			if (wr_sync) timer_sync_hold_q <= wdata_i[t16cp_pkg::BIT_SYNC_HOLD];
			shared_prescaler_reset_q <= psc_reset_next;
		end
	end

	// free running: clock select never touches it, only the shared reset
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) psc_q <= '0;
		else if (shared_prescaler_reset_q) psc_q <= '0;
		else psc_q <= psc_q + 10'h001;
	end

	// ticks held off while the prescaler sits in reset, so synced timers halt
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			timer16_tick_o <= 1'b0;
			other_tick_o   <= 1'b0;
		end else begin
			timer16_tick_o <= !shared_prescaler_reset_q
				&& tap_tick(clock_source_sel_q, psc_q, ext_rise_i, ext_fall_i);
			other_tick_o   <= !shared_prescaler_reset_q
				&& tap_tick(other_clock_source_sel_i, psc_q, ext_rise_i, ext_fall_i);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) rdata_o <= t16cp_pkg::RESET_BYTE;
		else if (!rd_i) rdata_o <= t16cp_pkg::RESET_BYTE;
		else if (io_space_i ? addr_i == t16cp_pkg::ADDR_FLAGS_IO
			: addr_i == t16cp_pkg::ADDR_FLAGS_DATA) rdata_o <= timer16_irq_flags_q;
		else if (!io_space_i && addr_i == t16cp_pkg::ADDR_MASK) rdata_o <= timer16_irq_mask_q;
		else if (!io_space_i && addr_i == t16cp_pkg::ADDR_CMP_A) rdata_o <= compare_a_value_q[7:0];
		else if (!io_space_i && addr_i == t16cp_pkg::ADDR_CMP_A + t16cp_pkg::ADDR_HIGH_STEP)
			rdata_o <= compare_a_value_q[15:8];
		else if (!io_space_i && addr_i == t16cp_pkg::ADDR_CMP_B) rdata_o <= compare_b_value_q[7:0];
		else if (!io_space_i && addr_i == t16cp_pkg::ADDR_CMP_B + t16cp_pkg::ADDR_HIGH_STEP)
			rdata_o <= compare_b_value_q[15:8];
		else if (hit(addr_i, io_space_i, t16cp_pkg::ADDR_SYNC))
			rdata_o <= {timer_sync_hold_q, 6'h00, shared_prescaler_reset_q};
		else if (!io_space_i && addr_i == t16cp_pkg::ADDR_CLKSEL)
			rdata_o <= {5'h00, clock_source_sel_q};
		else rdata_o <= t16cp_pkg::RESET_BYTE;
	end

	chk_irq_a_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		irq_req_o[1] |-> $past(global_irq_en_i)) else $error("match A irq without global enable");
	chk_irq_ovf_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		irq_req_o[0] |-> timer16_irq_mask_q[0] || $past(wr_mask)) else $error("ovf irq unmasked");
	chk_direct_tick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(clock_source_sel_q == t16cp_pkg::CS_DIRECT && !shared_prescaler_reset_q && !wr_cs)
		|=> timer16_tick_o) else $error("direct select missed a tick");
	chk_stop_notick: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(clock_source_sel_q == t16cp_pkg::CS_STOP && !wr_cs) [*2] |=> !timer16_tick_o)
		else $error("stopped timer ticked");
	chk_psc_reset: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		shared_prescaler_reset_q |=> psc_q == '0) else $error("prescaler not restarted");
	chk_psc_autoclr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(shared_prescaler_reset_q && !timer_sync_hold_q && !wr_sync) |=> !shared_prescaler_reset_q)
		else $error("prescaler reset stuck");
	chk_set_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		hw_set[t16cp_pkg::BIT_MATCH_A] |=> timer16_irq_flags_q[t16cp_pkg::BIT_MATCH_A])
		else $error("match A set lost");
	chk_w1c_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(sw_clr[t16cp_pkg::BIT_OVERFLOW] && !hw_set[t16cp_pkg::BIT_OVERFLOW])
		|=> !timer16_irq_flags_q[t16cp_pkg::BIT_OVERFLOW]) else $error("ovf not cleared");
	chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(timer16_irq_flags_q & ~t16cp_pkg::IRQ_BITS_MASK) == 8'h00)
		else $error("reserved flag bit set");
endmodule

// file: test/t16cp_cpu_model.sv
// cpu-side model: byte register accesses and interrupt vector execution
`timescale 1ns/1ps
module t16cp_cpu_model (
	input  wire logic       mclk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic [3:0] irq_req_i,
	input  wire logic       ack_en_i,
	output logic [7:0]      addr_o,
	output logic            io_space_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	output logic [3:0]      vector_ack_o
);
	initial begin
		{addr_o, io_space_o, wdata_o, wr_o, rd_o, vector_ack_o} = '0;
	end
	// released bus shows inverted values so stale data never looks valid
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic io);
		@(negedge mclk_i);
		{addr_o, wdata_o, io_space_o, wr_o} = {a, d, io, 1'b1};
		@(negedge mclk_i);
		{addr_o, wdata_o, wr_o} = {~a, ~d, 1'b0};
	endtask
	task automatic read_reg(input logic [7:0] a, input logic io, output logic [7:0] d);
		@(negedge mclk_i);
		{addr_o, io_space_o, rd_o} = {a, io, 1'b1};
		@(negedge mclk_i);
		{addr_o, rd_o} = {~a, 1'b0};
		d = rdata_i;
	endtask
	// vector runs for the lowest pending request only
	always @(negedge mclk_i) begin
		if (ack_en_i && vector_ack_o == 4'h0) begin
			vector_ack_o <= irq_req_i & (~irq_req_i + 4'h1);
		end else begin
			vector_ack_o <= 4'h0;
		end
	end
endmodule

// file: test/timer16_compare_irq_prescaler_bench.sv
// self-checking bench for the timer16 compare/prescaler block
`timescale 1ns/1ps
module timer16_compare_irq_prescaler_bench;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  addr, wdata, rdata, flags;
	logic        io_sp, wr, rd, m_a, m_b, f_a, f_b, tick16, tick8;
	logic        ack_en = 1'b0;
	logic        gie = 1'b0;
	logic        ovf_evt = 1'b0;
	logic        cap_evt = 1'b0;
	logic        ext_rise = 1'b0;
	logic        ext_fall = 1'b0;
	logic        cap_top = 1'b0;
	logic        top_hit = 1'b0;
	logic        ovf_mode = 1'b1;
	logic [15:0] count = 16'hffff;
	logic [2:0]  other_sel = 3'h0;
	logic [3:0]  vack, irq;
	logic [3:0]  seen = 4'h0;
	logic [7:0]  rst_addrs [6] = '{8'h36, 8'h6f, 8'h88, 8'h89, 8'h8a, 8'h8b};
	logic [2:0]  sel [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
	int          div [5] = '{1, 8, 64, 256, 1024};
	int          fbit [4] = '{0, 1, 2, 5};
	int          err_total = 0;
	int          checks = 0;
	int          n;
	always #10 mclk_i = ~mclk_i;
	always @(negedge mclk_i) seen <= seen | {f_b, f_a, m_b, m_a};
	t16cp_core t16cp_core_inst (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .io_space_i(io_sp),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .global_irq_en_i(gie),
		.timer16_count_i(count), .count_tick_i(1'b0), .overflow_evt_i(ovf_evt),
		.capture_evt_i(cap_evt), .capture_is_top_i(cap_top), .top_reached_i(top_hit),
		.wave_mode_ovf_i(ovf_mode), .ext_rise_i(ext_rise), .ext_fall_i(ext_fall),
		.other_clock_source_sel_i(other_sel), .vector_ack_i(vack), .rdata_o(rdata),
		.irq_req_o(irq), .match_a_o(m_a), .match_b_o(m_b), .force_match_a_o(f_a),
		.force_match_b_o(f_b), .timer16_tick_o(tick16), .other_tick_o(tick8),
		.timer16_irq_flags_o(flags));
	t16cp_cpu_model t16cp_cpu_model_inst (
		.mclk_i(mclk_i), .rdata_i(rdata), .irq_req_i(irq), .ack_en_i(ack_en),
		.addr_o(addr), .io_space_o(io_sp), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.vector_ack_o(vack));
	task automatic close_out;
		if (err_total == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic io);
		t16cp_cpu_model_inst.write_reg(a, d, io);
	endtask
	task automatic rd_chk(input string what, input logic [7:0] a, input logic io,
		input logic [7:0] exp);
		logic [7:0] v;
		t16cp_cpu_model_inst.read_reg(a, io, v);
		chk(what, {8'h00, exp}, {8'h00, v});
	endtask
	// bounded count of clocks until the chosen tick pulses
	task automatic tick_gap(input logic other, input int lim, output int k);
		k = 0;
		do begin
			@(negedge mclk_i);
			k++;
		end while (((other ? tick8 : tick16) !== 1'b1) && k < lim);
	endtask
	// count held two ticks so the stored match is not missed
	task automatic fire(input int k);
		@(negedge mclk_i);
		case (k)
			0: ovf_evt = 1'b1;
			1: count = 16'h1234;
			2: count = 16'h56cd;
			4: top_hit = 1'b1;
			default: cap_evt = 1'b1;
		endcase
		@(negedge mclk_i);
		{ovf_evt, cap_evt, top_hit} = 3'b000;
		@(negedge mclk_i);
		count = 16'hffff;
	endtask
	initial begin
		repeat (20000) @(posedge mclk_i);
		err_total++;
		close_out();
	end
	initial begin
		repeat (2) @(negedge mclk_i);
		rst_n_i = 1'b1;
		foreach (rst_addrs[i]) rd_chk("reset value", rst_addrs[i], 1'b0, 8'h00);
		rd_chk("unmapped", 8'h00, 1'b0, 8'h00);
		wr_reg(t16cp_pkg::ADDR_MASK, 8'hff, 1'b0);
		rd_chk("mask", t16cp_pkg::ADDR_MASK, 1'b0, t16cp_pkg::IRQ_BITS_MASK);
		wr_reg(8'h89, 8'h12, 1'b0);
		wr_reg(8'h88, 8'h34, 1'b0);
		wr_reg(8'h8b, 8'hab, 1'b0);
		wr_reg(8'h89, 8'h56, 1'b0);
		wr_reg(8'h8a, 8'hcd, 1'b0);
		rd_chk("cmp a low", 8'h88, 1'b0, 8'h34);
		rd_chk("cmp a high", 8'h89, 1'b0, 8'h12);
		rd_chk("cmp b high", 8'h8b, 1'b0, 8'h56);
		rd_chk("cmp b low", 8'h8a, 1'b0, 8'hcd);
		wr_reg(t16cp_pkg::ADDR_CLKSEL, 8'h01, 1'b0);
		for (int k = 0; k < 4; k++) begin
			gie = 1'b0;
			fire(k);
			repeat (4) @(negedge mclk_i);
			chk("flag set", 16'(1 << fbit[k]), {8'h00, flags});
			wr_reg(t16cp_pkg::ADDR_FLAGS_DATA, 8'h00, 1'b0);
			rd_chk("flags io", t16cp_pkg::ADDR_FLAGS_IO, 1'b1, 8'(1 << fbit[k]));
			chk("irq gated", 16'h0000, {12'h000, irq});
			gie = 1'b1;
			repeat (3) @(negedge mclk_i);
			chk("irq raised", 16'(1 << k), {12'h000, irq});
			ack_en = !k[0];
			if (k == 1) wr_reg(t16cp_pkg::ADDR_FLAGS_DATA, 8'h02, 1'b0);
			if (k == 3) wr_reg(t16cp_pkg::ADDR_FLAGS_IO, 8'h20, 1'b1);
			repeat (3) @(negedge mclk_i);
			ack_en = 1'b0;
			repeat (3) @(negedge mclk_i);
			chk("flag cleared", 16'h0000, {8'h00, flags});
		end
		chk("match pulses", 16'h0003, {14'h0000, seen[1:0]});
		wr_reg(t16cp_pkg::ADDR_FORCE, 8'hc0, 1'b0);
		repeat (4) @(negedge mclk_i);
		chk("force pulses", 16'h0003, {14'h0000, seen[3:2]});
		chk("force no flag", 16'h0000, {8'h00, flags});
		ovf_mode = 1'b0;
		fire(0);
		chk("ovf mode off", 16'h0000, {8'h00, flags});
		ovf_mode = 1'b1;
		cap_top = 1'b1;
		fire(3);
		chk("capture at top", 16'h0000, {8'h00, flags});
		fire(4);
		chk("top reached", 16'h0020, {8'h00, flags});
		cap_top = 1'b0;
		// clear of both bits lands on the same edge as a fresh overflow
		fork
			wr_reg(t16cp_pkg::ADDR_FLAGS_DATA, 8'h21, 1'b0);
			fire(0);
		join
		chk("set beats clear", 16'h0001, {8'h00, flags});
		wr_reg(t16cp_pkg::ADDR_FLAGS_DATA, 8'h01, 1'b0);
		chk("ovf cleared", 16'h0000, {8'h00, flags});
		for (int k = 0; k < 5; k++) begin
			wr_reg(t16cp_pkg::ADDR_CLKSEL, {5'h00, sel[k]}, 1'b0);
			tick_gap(1'b0, 1100, n);
			tick_gap(1'b0, 1100, n);
			chk("tick period", 16'(div[k]), 16'(n));
		end
		other_sel = t16cp_pkg::CS_DIV64;
		tick_gap(1'b1, 1100, n);
		tick_gap(1'b1, 1100, n);
		chk("other period", 16'd64, 16'(n));
		wr_reg(t16cp_pkg::ADDR_CLKSEL, 8'h00, 1'b0);
		repeat (2) @(negedge mclk_i);
		tick_gap(1'b0, 40, n);
		chk("stopped", 16'd40, 16'(n));
		wr_reg(t16cp_pkg::ADDR_CLKSEL, 8'h07, 1'b0);
		// edge pulse held until its tick shows, one clock later
		ext_rise = 1'b1;
		tick_gap(1'b0, 10, n);
		ext_rise = 1'b0;
		chk("ext tick", 16'd1, 16'(n));
		wr_reg(t16cp_pkg::ADDR_CLKSEL, 8'h06, 1'b0);
		ext_fall = 1'b1;
		tick_gap(1'b0, 10, n);
		ext_fall = 1'b0;
		chk("ext fall tick", 16'd1, 16'(n));
		ext_rise = 1'b1;
		tick_gap(1'b0, 4, n);
		ext_rise = 1'b0;
		chk("fall ignores rise", 16'd4, 16'(n));
		wr_reg(t16cp_pkg::ADDR_CLKSEL, 8'h02, 1'b0);
		other_sel = t16cp_pkg::CS_DIV8;
		wr_reg(t16cp_pkg::ADDR_SYNC, 8'h81, 1'b0);
		repeat (2) @(negedge mclk_i);
		tick_gap(1'b0, 60, n);
		chk("held own", 16'd60, 16'(n));
		tick_gap(1'b1, 60, n);
		chk("held other", 16'd60, 16'(n));
		wr_reg(t16cp_pkg::ADDR_SYNC, 8'h00, 1'b0);
		tick_gap(1'b0, 20, n);
		chk("restart", 16'd8, 16'(n));
		chk("together", 16'h0001, {15'h0000, tick8});
		wr_reg(t16cp_pkg::ADDR_SYNC, 8'h01, 1'b0);
		tick_gap(1'b0, 20, n);
		chk("auto clear", 16'd9, 16'(n));
		close_out();
	end
endmodule
